// ---- common/omd_pkg.sv ----
package omd_pkg;

  // ----------------------------------------
  // Requester ports, fixed priority by index
  // ----------------------------------------
  localparam int NREQ = 9;
  localparam int REQ_FETCH = 0;      // Program bus, 32-bit fetch
  localparam int REQ_RD32 = 1;       // 32-bit data read bus
  localparam int REQ_RD16A = 2;
  localparam int REQ_RD16B = 3;
  localparam int REQ_WR16A = 4;
  localparam int REQ_WR16B = 5;
  localparam int REQ_DMA = 6;
  localparam int REQ_USB = 7;
  localparam int REQ_LCD = 8;
  localparam int FIRST_MASTER = REQ_DMA;

  // ----------------------------------------
  // Address map
  // ----------------------------------------
  localparam int CPU_ADDR_W = 24;    // 16M-byte unified space
  localparam int IO_ADDR_W = 16;     // 64K-word I/O space
  localparam logic [23:0] MMR_END = 24'h0000bf;
  localparam logic [23:0] DUAL_ACCESS_RAM_END = 24'h00ffff;
  localparam logic [23:0] SINGLE_ACCESS_RAM_BASE = 24'h010000;
  localparam logic [23:0] SINGLE_ACCESS_RAM_END = 24'h04ffff;
  localparam logic [23:0] ROM_BASE = 24'hfe0000;
  localparam logic [31:0] MST_DUAL_ACCESS_RAM_BASE = 32'h00010000;
  localparam logic [31:0] MST_DUAL_ACCESS_RAM_END = 32'h0001ffff;
  localparam logic [31:0] MST_DUAL_ACCESS_RAM_OFS = 32'h00010000;
  localparam logic [31:0] MST_SINGLE_ACCESS_RAM_BASE = 32'h00090000;
  localparam logic [31:0] MST_SINGLE_ACCESS_RAM_END = 32'h000cffff;
  localparam logic [31:0] MST_SINGLE_ACCESS_RAM_OFS = 32'h00080000;

  // ----------------------------------------
  // Block organisation and per-cycle capacity
  // ----------------------------------------
  localparam int DUAL_ACCESS_RAM_BLOCKS = 8;
  localparam int SINGLE_ACCESS_RAM_BLOCKS = 32;
  localparam int ROM_BLOCKS = 4;
  localparam logic [1:0] DUAL_ACCESS_RAM_PORTS = 2'h2;
  localparam logic [1:0] SINGLE_ACCESS_RAM_PORTS = 2'h1;
  localparam logic [1:0] ROM_PORTS = 2'h1;

  typedef enum logic [2:0] {
    REG_NONE = 3'b000,
    REG_MMR = 3'b001,
    REG_DUAL_ACCESS_RAM = 3'b010,
    REG_SINGLE_ACCESS_RAM = 3'b011,
    REG_ROM = 3'b100,
    REG_EXT = 3'b101,
    REG_IO = 3'b110,
    REG_UNMAPPED = 3'b111
  } omd_region_e;

  typedef struct packed {
    logic valid;
    logic write;
    logic io;
    logic [31:0] addr;
  } omd_req_s;

  typedef struct packed {
    logic grant;
    logic stall;
    logic error;
    omd_region_e region;
    logic [5:0] block;
    logic [15:0] offset;
  } omd_res_s;

endpackage

// ---- rtl/omd_decoder.sv ----
// Functional notes
// - CPU bytes 0-FFFF map to DUAL_ACCESS_RAM blocks
// - DUAL_ACCESS_RAM block serves two accesses per cycle
// - DUAL_ACCESS_RAM reachable by program, data, DMA buses
// - DMA sees DUAL_ACCESS_RAM at CPU address plus 10000h
// - Lowest 192 bytes are mapped-register area
// - CPU bytes 10000-4FFFF map to 32 SINGLE_ACCESS_RAM blocks
// - SINGLE_ACCESS_RAM block serves one access per cycle
// - SINGLE_ACCESS_RAM also reachable by USB and LCD
// - DMA/USB see SINGLE_ACCESS_RAM at CPU address plus 80000h
// - ROM at FE0000-FFFFFF, four blocks, no waits
// - Disable flag set unmaps the ROM region
// - Hardware reset clears the ROM disable flag
// - Software reset leaves ROM disable flag alone
// - ROM reachable only from program/data buses
// - Each ROM block does one word per cycle
// - 16M-byte unified space plus 64K-word I/O
// - Program fetches are aligned 32-bit words
// - DMA moves one 32-bit word per cycle
// - Four reads, two writes per cycle on buses
`timescale 1ns/100ps
`default_nettype none

module omd_decoder
  import omd_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire omd_req_s req [NREQ],
  input wire logic tsr_wr_en,
  input wire logic tsr_rom_disable,
  input wire logic soft_reset,
  output omd_res_s res [NREQ],
  output logic rom_disable_flag
);

  // ----------------------------------------
  // Address decode
  // ----------------------------------------

  // Turns one request into region, block and word offset; errors mark
  // unmapped space and regions the requester may not reach
  function automatic omd_res_s decode(omd_req_s r, logic cpu, logic lite, logic rom_dis);
    omd_res_s d;
    logic [23:0] a;
    logic [23:0] s;
    logic [31:0] m;
    d = '0;
    a = '0;
    s = '0;
    m = r.addr;
    if (r.io) begin
      d.region = REG_IO;
      d.offset = r.addr[IO_ADDR_W-1:0];
      return d;
    end
    if (cpu) begin
      a = r.addr[CPU_ADDR_W-1:0];
    end else if (m >= MST_DUAL_ACCESS_RAM_BASE && m <= MST_DUAL_ACCESS_RAM_END) begin
      m = m - MST_DUAL_ACCESS_RAM_OFS;
      a = m[CPU_ADDR_W-1:0];
    end else if (m >= MST_SINGLE_ACCESS_RAM_BASE && m <= MST_SINGLE_ACCESS_RAM_END) begin
      m = m - MST_SINGLE_ACCESS_RAM_OFS;
      a = m[CPU_ADDR_W-1:0];
    end else begin
      d.region = REG_UNMAPPED;
      d.error = 1'b1;
      return d;
    end
    if (a <= MMR_END) begin
      d.region = REG_MMR;
      d.offset = {8'h00, a[7:0]};
      d.error = lite;
    end else if (a <= DUAL_ACCESS_RAM_END) begin
      d.region = REG_DUAL_ACCESS_RAM;
      d.block = {3'h0, a[15:13]};
      d.offset = {4'h0, a[12:1]};
      d.error = lite; // USB and LCD have no DUAL_ACCESS_RAM path
    end else if (a >= SINGLE_ACCESS_RAM_BASE && a <= SINGLE_ACCESS_RAM_END) begin
      s = a - SINGLE_ACCESS_RAM_BASE;
      d.region = REG_SINGLE_ACCESS_RAM;
      d.block = {1'b0, s[17:13]};
      d.offset = {4'h0, s[12:1]};
    end else if (a >= ROM_BASE) begin
      if (cpu && !rom_dis) begin
        d.region = REG_ROM;
        d.block = {4'h0, a[16:15]};
        d.offset = {2'h0, a[14:1]};
      end else begin
        d.region = REG_UNMAPPED;
        d.error = 1'b1;
      end
    end else begin
      // CPU goes out to the external interface; masters have no route
      d.region = cpu ? REG_EXT : REG_UNMAPPED;
      d.error = !cpu;
    end
    return d;
  endfunction

  // ----------------------------------------
  // ROM disable flag
  // ----------------------------------------

  logic rom_dis_reg;

  // Of the two resets only hardware reset clears it; soft_reset is deliberately not read here
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rom_dis_reg <= 1'b0;
    end else if (tsr_wr_en) begin
      rom_dis_reg <= tsr_rom_disable;
    end
  end

  assign rom_disable_flag = rom_dis_reg;

  // ----------------------------------------
  // Per-block arbitration
  // ----------------------------------------

  logic [1:0] dr_use [DUAL_ACCESS_RAM_BLOCKS];
  logic [1:0] sr_use [SINGLE_ACCESS_RAM_BLOCKS];
  logic [1:0] rm_use [ROM_BLOCKS];
  omd_res_s dec [NREQ];
  omd_res_s res_next [NREQ];
  omd_req_s rq [NREQ];
  omd_res_s res_reg [NREQ];

  // Walks requesters in index order so lower indices win; a loser stalls
  // and must hold its request into a later cycle
  always_comb begin
    for (int b = 0; b < DUAL_ACCESS_RAM_BLOCKS; b++) begin
      dr_use[b] = 2'h0;
    end
    for (int b = 0; b < SINGLE_ACCESS_RAM_BLOCKS; b++) begin
      sr_use[b] = 2'h0;
    end
    for (int b = 0; b < ROM_BLOCKS; b++) begin
      rm_use[b] = 2'h0;
    end
    for (int i = 0; i < NREQ; i++) begin
      rq[i] = req[i];
      if (i == REQ_FETCH) begin
        rq[i].addr[1:0] = 2'b00; // 32-bit program words
      end
      dec[i] = decode(rq[i], i < FIRST_MASTER, i == REQ_USB || i == REQ_LCD, rom_dis_reg);
      res_next[i] = dec[i];
      res_next[i].grant = 1'b0;
      res_next[i].stall = 1'b0;
      if (!rq[i].valid) begin
        res_next[i] = '0;
      end else if (dec[i].error) begin
        res_next[i].grant = 1'b1; // Completes at once with error set
      end else begin
        unique case (dec[i].region)
          REG_DUAL_ACCESS_RAM: begin
            if (dr_use[dec[i].block[2:0]] < DUAL_ACCESS_RAM_PORTS) begin
              res_next[i].grant = 1'b1;
              dr_use[dec[i].block[2:0]] = dr_use[dec[i].block[2:0]] + 2'h1;
            end else begin
              res_next[i].stall = 1'b1;
            end
          end
          REG_SINGLE_ACCESS_RAM: begin
            if (sr_use[dec[i].block[4:0]] < SINGLE_ACCESS_RAM_PORTS) begin
              res_next[i].grant = 1'b1;
              sr_use[dec[i].block[4:0]] = sr_use[dec[i].block[4:0]] + 2'h1;
            end else begin
              res_next[i].stall = 1'b1;
            end
          end
          REG_ROM: begin
            if (rm_use[dec[i].block[1:0]] < ROM_PORTS) begin
              res_next[i].grant = 1'b1; // no wait states
              rm_use[dec[i].block[1:0]] = rm_use[dec[i].block[1:0]] + 2'h1;
            end else begin
              res_next[i].stall = 1'b1;
            end
          end
          default: begin
            // MAPPED_REGISTER_AREA, I/O and external accesses are handed on without a block limit
            res_next[i].grant = 1'b1;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Registered answers
  // ----------------------------------------

  // All nine buses are judged together each cycle, so the CPU's four reads
  // and two writes and a DMA word can all land in one cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NREQ; i++) begin
        res_reg[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NREQ; i++) begin
        res_reg[i] <= res_next[i];
      end
    end
  end

  assign res = res_reg;

endmodule

`default_nettype wire

// ---- verification/omd_sva.sv ----
`timescale 1ns/100ps
`default_nettype none
module omd_sva
  import omd_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire omd_req_s req [NREQ],
  input wire logic tsr_wr_en,
  input wire logic tsr_rom_disable,
  input wire logic soft_reset,
  input wire omd_res_s res [NREQ],
  input wire logic rom_disable_flag
);
  // ----------------------------------------
  // ROM flag, decode and arbitration checks
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [31:0] a0, a1, a3;
  // Short names for the address fields under test
  assign a0 = req[0].addr;
  assign a1 = req[1].addr;
  assign a3 = req[3].addr;
  flag_write_a: assert property (
    tsr_wr_en |=> rom_disable_flag == $past(tsr_rom_disable)) else $error("flag write lost");
  flag_hold_a: assert property (
    !tsr_wr_en |=> $stable(rom_disable_flag)) else $error("flag moved without a write");
  top_grant_a: assert property (
    req[0].valid |=> res[0].grant && !res[0].stall) else $error("top port not granted");
  mmr_dec_a: assert property (
    req[0].valid && !req[0].io && a0[23:0] <= MMR_END |=> res[0].region == REG_MMR)
    else $error("register area missed");
  dual_access_ram_dec_a: assert property (
    req[0].valid && !req[0].io && a0[23:16] == 8'h0 && a0[15:0] >= 16'h00c0
    |=> res[0].region == REG_DUAL_ACCESS_RAM && res[0].block == $past(a0[15:13])) else $error("dual ram decode");
  single_access_ram_dec_a: assert property (
    req[1].valid && !req[1].io && a1[23:0] >= SINGLE_ACCESS_RAM_BASE && a1[23:0] <= SINGLE_ACCESS_RAM_END |=> res[1].stall
    || (res[1].region == REG_SINGLE_ACCESS_RAM && res[1].block == $past((a1[23:0] - SINGLE_ACCESS_RAM_BASE) >> 13)))
    else $error("single ram decode");
  // The flag seen at the request edge decides, so writes in that cycle are skipped
  rom_dec_a: assert property (
    req[0].valid && !req[0].io && a0[23:0] >= ROM_BASE && !tsr_wr_en
    |=> res[0].region == ($past(rom_disable_flag) ? REG_UNMAPPED : REG_ROM)) else $error("rom decode");
  sar_single_a: assert property (
    req[1].valid && req[2].valid && !req[1].io && !req[2].io && a1[23:13] == req[2].addr[23:13]
    && a1[23:0] >= SINGLE_ACCESS_RAM_BASE && a1[23:0] <= SINGLE_ACCESS_RAM_END |=> res[2].stall) else $error("second access let in");
  dual_grant_a: assert property (
    req[1].valid && req[3].valid && !req[0].valid && !req[2].valid && !req[1].io && !req[3].io
    && a1[23:16] == 8'h0
    && a1[15:0] >= 16'h00c0 && a1[23:13] == a3[23:13] |=> res[1].grant && res[3].grant)
    else $error("dual ram refused a pair");
endmodule
bind omd_decoder omd_sva omd_sva_inst (.clk(clk), .rst(rst), .req(req), .tsr_wr_en(tsr_wr_en),
  .tsr_rom_disable(tsr_rom_disable), .soft_reset(soft_reset), .res(res),
  .rom_disable_flag(rom_disable_flag));
`default_nettype wire

// ---- verification/omd_master.sv ----
`timescale 1ns/100ps
`default_nettype none
// Requester that retries a refused read
module omd_master
  import omd_pkg::*;
(
  input wire logic clk,
  input wire logic go,
  input wire logic [31:0] a,
  input wire omd_res_s res,
  output omd_req_s rq
);
  logic hold_reg = 1'b0;
  // Hold the request while the answer says stall
  // A stall is only ever answered to a live request, so it alone decides the
  // retry; reading go here would race the bench at the same falling edge
  always @(negedge clk) hold_reg <= res.stall;
  // Idle address is inverted so stale values are not mistaken for live ones
  assign rq = '{go || hold_reg, 1'b0, 1'b0, (go || hold_reg) ? a : ~a};
endmodule
`default_nettype wire

// ---- verification/onchip_memory_map_decoder_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
module onchip_memory_map_decoder_bench;
  import omd_pkg::*;
  // ----------------------------------------
  // Harness
  // ----------------------------------------
  logic clk = 0, rst = 1, wen = 0, wd = 0, sr = 0, pgo = 0, flag;
  logic [31:0] pa = 0;
  omd_req_s rq [NREQ], req [NREQ], pm;
  omd_res_s res [NREQ];
  int mismatches = 0, n_compared = 0, cyc = 0;
  always #5 clk = ~clk;
  // The retrying master owns one read port
  always_comb begin
    req = rq;
    req[REQ_RD16A] = pm;
  end
  omd_decoder omd_decoder_inst (.clk(clk), .rst(rst), .req(req), .tsr_wr_en(wen),
    .tsr_rom_disable(wd), .soft_reset(sr), .res(res), .rom_disable_flag(flag));
  omd_master omd_master_inst (.clk(clk), .go(pgo), .a(pa), .res(res[REQ_RD16A]), .rq(pm));
  task complete_run;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Runs take about 55 cycles, so 5000 means a hang
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      complete_run;
    end
  end
  task chk(string n, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // One read on port i; its answer stands one cycle after it is taken
  task acc(int i, logic [31:0] a, logic [2:0] rg, logic [5:0] b, logic e);
    @(negedge clk);
    rq[i] = '{1'b1, 1'b0, 1'b0, a};
    @(negedge clk);
    rq[i].valid = 1'b0;
    chk("region", rg, res[i].region);
    chk("error", e, res[i].error);
    if (!e) chk("block", b, res[i].block);
  endtask
  task t_flag;
    chk("flag after reset", 0, flag);
    @(negedge clk);
    wen = 1;
    wd = 1;
    @(negedge clk);
    wen = 0;
    sr = 1;
    @(negedge clk);
    sr = 0;
    chk("flag set", 1, flag);
    acc(REQ_FETCH, 32'hfe0000, REG_UNMAPPED, 0, 1);
    rst = 1;
    @(negedge clk);
    rst = 0;
    chk("flag hw reset", 0, flag);
    chk("res after reset", 0, res[REQ_FETCH]);
    acc(REQ_RD32, 32'hfe0000, REG_ROM, 0, 0);
    $display("t_flag done");
  endtask
  task t_map;
    acc(REQ_FETCH, 32'h0, REG_MMR, 0, 0);
    acc(REQ_RD32, 32'hc0, REG_DUAL_ACCESS_RAM, 0, 0);
    acc(REQ_FETCH, 32'he000, REG_DUAL_ACCESS_RAM, 7, 0);
    acc(REQ_RD32, 32'h10000, REG_SINGLE_ACCESS_RAM, 0, 0);
    acc(REQ_FETCH, 32'h4fffc, REG_SINGLE_ACCESS_RAM, 31, 0);
    acc(REQ_DMA, 32'h1e000, REG_DUAL_ACCESS_RAM, 7, 0);
    acc(REQ_DMA, 32'h90000, REG_SINGLE_ACCESS_RAM, 0, 0);
    acc(REQ_USB, 32'hcfffc, REG_SINGLE_ACCESS_RAM, 31, 0);
    acc(REQ_LCD, 32'h96000, REG_SINGLE_ACCESS_RAM, 3, 0);
    acc(REQ_USB, 32'hfe0000, REG_UNMAPPED, 0, 1);
    acc(REQ_RD16B, 32'hff8000, REG_ROM, 3, 0);
    $display("t_map done");
  endtask
  task t_stall;
    @(negedge clk);
    rq[REQ_RD32] = '{1'b1, 1'b0, 1'b0, 32'h16000};
    pa = 32'h16002;
    pgo = 1;
    @(negedge clk);
    pgo = 0;
    rq[REQ_RD32].valid = 1'b0;
    chk("rd32 grant", 1, res[REQ_RD32].grant);
    chk("rd16 stall", 1, res[REQ_RD16A].stall);
    @(negedge clk);
    chk("rd16 retry", 1, res[REQ_RD16A].grant);
    $display("t_stall done");
  endtask
  task t_dual;
    @(negedge clk);
    rq[REQ_RD32] = '{1'b1, 1'b0, 1'b0, 32'h2000};
    rq[REQ_RD16B] = '{1'b1, 1'b0, 1'b0, 32'h2002};
    rq[REQ_DMA] = '{1'b1, 1'b0, 1'b0, 32'h12004};
    @(negedge clk);
    rq[REQ_RD32].valid = 1'b0;
    rq[REQ_RD16B].valid = 1'b0;
    rq[REQ_DMA].valid = 1'b0;
    chk("pair grant", 2, res[REQ_RD32].grant + res[REQ_RD16B].grant);
    chk("third stall", 1, res[REQ_DMA].stall);
    $display("t_dual done");
  endtask
  // I/O, external space, offsets and a write pair in one cycle
  task t_view;
    @(negedge clk);
    rq[REQ_RD32] = '{1'b1, 1'b0, 1'b1, 32'h1c00};
    rq[REQ_RD16B] = '{1'b1, 1'b0, 1'b0, 32'h60000};
    rq[REQ_WR16A] = '{1'b1, 1'b1, 1'b0, 32'h2006};
    rq[REQ_WR16B] = '{1'b1, 1'b1, 1'b0, 32'h3ffe};
    @(negedge clk);
    for (int i = 0; i < NREQ; i++) rq[i].valid = 1'b0;
    chk("io region", REG_IO, res[REQ_RD32].region);
    chk("io offset", 32'h1c00, res[REQ_RD32].offset);
    chk("ext region", REG_EXT, res[REQ_RD16B].region);
    chk("ext error", 0, res[REQ_RD16B].error);
    chk("wr a grant", 1, res[REQ_WR16A].grant);
    chk("wr a offset", 3, res[REQ_WR16A].offset);
    chk("wr b grant", 1, res[REQ_WR16B].grant);
    chk("wr b offset", 32'hfff, res[REQ_WR16B].offset);
    chk("wr b block", 1, res[REQ_WR16B].block);
    chk("idle port", 0, res[REQ_LCD]);
    $display("t_view done");
  endtask
  initial begin
    for (int i = 0; i < NREQ; i++) rq[i] = '0;
    repeat (16) @(negedge clk);
    rst = 0;
    t_flag;
    t_map;
    t_stall;
    t_dual;
    t_view;
    complete_run;
  end
endmodule
`default_nettype wire
